// *** i2c_mode_assertions.sv ***
// Purpose: port-level checks of the mode register and bus sequencing
// Assumes: open-drain pins, oe high pulls the line low
// Notes: bound to the top module of the block
`timescale 1ns/100ps
module i2c_mode_checker (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic link_clock,
	input wire logic mode_write,
	input wire logic [31:0] mode_wdata,
	input wire logic [31:0] mode_rdata,
	input wire logic receive_strobe,
	input wire logic busy,
	input wire logic scl_oe,
	input wire logic sda_oe
);
	// register readback
	property p_reserved_zero;
		@(posedge clock) disable iff (!rst_n) mode_rdata[31:16] == 16'h0000 && !mode_rdata[12];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
	property p_write_lands;
		@(posedge clock) disable iff (!rst_n)
		mode_write |=> mode_rdata[15:0] == ($past(mode_wdata[15:0]) & i2c_mode_pkg::MODE_WRITE_MASK);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write not taken");
	// pins released while disabled or idle slave
	property p_disabled;
		@(posedge link_clock) disable iff (!rst_n) !mode_rdata[5] [*6] |-> !scl_oe && !sda_oe;
	endproperty
	a_disabled: assert property (p_disabled) else $error("pins driven while disabled");
	property p_slave_quiet;
		@(posedge link_clock) disable iff (!rst_n)
		(!mode_rdata[13] && !mode_rdata[10]) [*6] |-> !sda_oe && !scl_oe;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet) else $error("idle slave drives bus");
	// self clears
	property p_stop_clear;
		@(posedge clock) disable iff (!rst_n)
		$fell(mode_rdata[11]) && !$past(mode_write) |-> !scl_oe && !sda_oe ##[0:8] !mode_rdata[10];
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stop clear without stop");
	property p_start_clear;
		@(posedge clock) disable iff (!rst_n)
		$fell(mode_rdata[13]) && !$past(mode_write) |-> ##[0:6] busy;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("start clear while idle");
	property p_start_go;
		@(posedge clock) disable iff (!rst_n)
		$rose(mode_rdata[13]) && mode_rdata[10] && mode_rdata[5] && !mode_rdata[7] |-> ##[1:300] busy;
	endproperty
	a_start_go: assert property (p_start_go) else $error("start request ignored");
	property p_combo_idle;
		@(posedge clock) disable iff (!rst_n)
		(mode_rdata[13] && mode_rdata[11] && mode_rdata[7] && !busy) [*3] |=> !busy;
	endproperty
	a_combo_idle: assert property (p_combo_idle) else $error("reserved combination ran");
	property p_strobe_pulse;
		@(posedge clock) disable iff (!rst_n) receive_strobe |=> !receive_strobe;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
	// main scenarios reached
	c_receive: cover property (@(posedge clock) receive_strobe);
	c_stop: cover property (@(posedge clock) $fell(mode_rdata[11]));
	c_start: cover property (@(posedge clock) $fell(mode_rdata[13]));
endmodule : i2c_mode_checker

bind i2c_mode_control i2c_mode_checker i_i2c_mode_checker (.clock(clock), .rst_n(rst_n),
	.link_clock(link_clock), .mode_write(mode_write), .mode_wdata(mode_wdata),
	.mode_rdata(mode_rdata), .receive_strobe(receive_strobe), .busy(busy),
	.scl_oe(scl_oe), .sda_oe(sda_oe));

// *** i2c_mode_control.sv ***
// Purpose: mode register and bus sequencing of a two-wire serial controller
// Assumes: link_clock is the prescaled module clock; pins are open drain
// Notes: one bit takes four link_clock cycles as master; no clock stretching
`timescale 1ns/100ps
module i2c_mode_control (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic link_clock,
	input wire logic mode_write,
	input wire logic [31:0] mode_wdata,
	output logic [31:0] mode_rdata,
	input wire logic [15:0] data_count,
	input wire logic [9:0] target_address,
	input wire logic [9:0] own_address,
	input wire logic [7:0] transmit_data,
	output logic [7:0] receive_data,
	output logic receive_strobe,
	output logic busy,
	input wire logic debug_halt,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);

	typedef struct packed {
		i2c_mode_pkg::mode_control_type mode;
		logic [15:0] count_hold;
		logic [9:0] target_hold;
		logic [3:0] tg_s1;
		logic [3:0] tg_s2;
		logic [3:0] tg_prev;
		logic busy_s1;
		logic busy_s2;
		logic [7:0] rx_data;
		logic rx_pulse;
	} sys_state_type;

	typedef struct packed {
		logic [15:0] cfg_s1;
		i2c_mode_pkg::mode_control_type cfg;
		logic [2:0] pin_s1;
		logic [2:0] pin_s2;
		logic [1:0] pin_prev;
		i2c_mode_pkg::link_state_type st;
		logic [1:0] q;
		logic [3:0] bitcnt;
		logic [7:0] sh;
		logic [16:0] cnt;
		logic [1:0] stage;
		logic recv;
		logic mnack;
		logic stt_seen;
		logic stp_seen;
		logic scl_oe;
		logic sda_oe;
		logic [3:0] tg;
		logic [7:0] rx_hold;
		logic [3:0] lp_cnt;
		logic [7:0] lp_word;
		logic busy;
	} link_state_type_regs_type;

	logic [1:0] rst_sync_reg;
	logic [1:0] link_rst_sync_reg;
	logic sys_rst_n;
	logic link_rst_n;
	sys_state_type s_reg;
	sys_state_type s_next;
	link_state_type_regs_type l_reg;
	link_state_type_regs_type l_next;
	i2c_mode_pkg::mode_control_type c;
	logic [3:0] ev;
	logic [3:0] nbits;
	logic [3:0] byte_len;
	logic [7:0] tx_word;
	logic [9:0] addr_src;
	logic [7:0] addr_first;
	logic [7:0] load_byte;
	logic load_recv;
	logic [1:0] first_stage;
	logic scl_now;
	logic sda_now;
	logic halt_now;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic m_freeze;
	logic m_last;
	logic m_nack;
	logic s_match;
	logic s_ack;

	// reset release, one synchroniser per domain
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	always_ff @(posedge link_clock or negedge rst_n) begin
		if (!rst_n) begin
			link_rst_sync_reg <= 2'h0;
		end else begin
			link_rst_sync_reg <= {link_rst_sync_reg[0], 1'b1};
		end
	end

	assign sys_rst_n = rst_sync_reg[1];
	assign link_rst_n = link_rst_sync_reg[1];

	// toggle events from the link: start, stop, noack, receive word
	assign ev = s_reg.tg_s2 ^ s_reg.tg_prev;

	// system domain: mode register with hardware self-clears
	always_comb begin
		s_next = s_reg;
		s_next.tg_s1 = l_reg.tg;
		s_next.tg_s2 = s_reg.tg_s1;
		s_next.tg_prev = s_reg.tg_s2;
		s_next.busy_s1 = l_reg.busy;
		s_next.busy_s2 = s_reg.busy_s1;
		s_next.rx_pulse = ev[3];
		if (ev[3]) begin
			s_next.rx_data = l_reg.rx_hold;
		end
		if (ev[0]) begin
			s_next.mode.start = 1'b0; // [R7]
		end
		if (ev[1]) begin
			s_next.mode.stop = 1'b0; // [R9]
			s_next.mode.master = 1'b0; // [R10]
		end
		if (ev[2]) begin
			s_next.mode.noack = 1'b0; // [R3]
		end
		// a software write lands after the clears, so the set wins
		if (mode_write) begin
			s_next.mode = i2c_mode_pkg::mode_control_type'(mode_wdata[15:0]
				& i2c_mode_pkg::MODE_WRITE_MASK); // [R22]
			if (mode_wdata[13]) begin
				s_next.count_hold = data_count;
				s_next.target_hold = target_address;
			end
		end
	end

	always_ff @(posedge clock or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// link-side decodes
	assign c = l_reg.cfg;
	assign nbits = (c.word_size == 3'h0) ? i2c_mode_pkg::FULL_WORD : {1'b0, c.word_size}; // [R18]
	assign byte_len = (l_reg.stage == i2c_mode_pkg::STAGE_DATA) ? nbits : i2c_mode_pkg::FULL_WORD;
	assign tx_word = 8'(transmit_data << (i2c_mode_pkg::FULL_WORD - nbits)); // [R19]
	assign addr_src = c.loop ? own_address : s_reg.target_hold; // [R14]
	assign addr_first = c.addr_width ? {i2c_mode_pkg::TEN_BIT_HEADER, addr_src[9:8], 1'b0}
		: {addr_src[6:0], ~c.transmit}; // [R12]
	assign first_stage = c.free_format ? i2c_mode_pkg::STAGE_DATA
		: i2c_mode_pkg::STAGE_ADDR_HI; // [R17]
	assign load_byte = (l_reg.stage == i2c_mode_pkg::STAGE_SBYTE) ? i2c_mode_pkg::START_BYTE
		: (l_reg.stage == i2c_mode_pkg::STAGE_ADDR_HI) ? addr_first
		: (l_reg.stage == i2c_mode_pkg::STAGE_ADDR_LO) ? addr_src[7:0] : tx_word;
	assign load_recv = (l_reg.stage == i2c_mode_pkg::STAGE_DATA) & ~c.transmit; // [R11]
	assign scl_now = l_reg.pin_s2[0];
	assign sda_now = l_reg.pin_s2[1];
	assign halt_now = l_reg.pin_s2[2];
	assign scl_rise = scl_now & ~l_reg.pin_prev[0];
	assign scl_fall = ~scl_now & l_reg.pin_prev[0];
	assign start_cond = scl_now & ~sda_now & l_reg.pin_prev[1];
	assign stop_cond = scl_now & sda_now & ~l_reg.pin_prev[1];
	assign m_freeze = halt_now & ~c.free_run & ~l_reg.q[1]; // [R5]
	assign m_last = ~c.repeat_on & (l_reg.cnt == i2c_mode_pkg::COUNT_LAST);
	assign m_nack = c.noack | m_last; // [R2] [R3]
	assign s_match = (l_reg.stage == i2c_mode_pkg::STAGE_ADDR_LO) ? (l_reg.sh == own_address[7:0])
		: (l_reg.sh != i2c_mode_pkg::START_BYTE) & (c.addr_width
		? (l_reg.sh[7:1] == {i2c_mode_pkg::TEN_BIT_HEADER, own_address[9:8]})
		: (l_reg.sh[7:1] == own_address[6:0])); // [R12] [R16]
	assign s_ack = l_reg.recv & ((l_reg.stage == i2c_mode_pkg::STAGE_DATA)
		? ~c.noack : s_match); // [R1] [R3]

	// link domain: bus sequencer for master and slave roles
	always_comb begin
		l_next = l_reg;
		l_next.cfg_s1 = s_reg.mode;
		l_next.cfg = i2c_mode_pkg::mode_control_type'(l_reg.cfg_s1);
		l_next.pin_s1 = {debug_halt, sda_in, scl_in};
		l_next.pin_s2 = l_reg.pin_s1;
		l_next.pin_prev = l_reg.pin_s2[1:0];
		l_next.busy = (l_reg.st != i2c_mode_pkg::LS_IDLE);
		if (!c.start) begin
			l_next.stt_seen = 1'b0;
		end
		if (!c.stop) begin
			l_next.stp_seen = 1'b0;
		end
		// loopback word returns after a fixed delay
		if (l_reg.lp_cnt != 4'h0) begin
			l_next.lp_cnt = l_reg.lp_cnt - 4'h1;
			if (l_reg.lp_cnt == 4'h1) begin
				l_next.rx_hold = l_reg.lp_word; // [R14]
				l_next.tg[3] = ~l_reg.tg[3];
			end
		end
		if (!c.enable) begin
			l_next.st = i2c_mode_pkg::LS_IDLE; // [R15]
			l_next.q = i2c_mode_pkg::Q_DRIVE;
			l_next.scl_oe = 1'b0; // [R15]
			l_next.sda_oe = 1'b0; // [R15]
			l_next.lp_cnt = 4'h0;
		end else if (c.master) begin
			if (!m_freeze) begin
				l_next.q = l_reg.q + 2'h1;
				unique case (l_reg.st)
					i2c_mode_pkg::LS_IDLE: begin
						l_next.q = i2c_mode_pkg::Q_DRIVE;
						if (c.start && !l_reg.stt_seen && !(c.repeat_on && c.stop)) begin // [R20] [R21]
							l_next.stt_seen = 1'b1;
							l_next.st = i2c_mode_pkg::LS_START; // [R7]
							l_next.cnt = (s_reg.count_hold == 16'h0) ? i2c_mode_pkg::COUNT_ZERO_LOAD
								: {1'b0, s_reg.count_hold}; // [R23]
							l_next.stage = c.sbyte ? i2c_mode_pkg::STAGE_SBYTE : first_stage; // [R16]
						end else if (c.stop && !c.start && !l_reg.stp_seen) begin
							l_next.stp_seen = 1'b1;
							l_next.st = i2c_mode_pkg::LS_STOP; // [R20] [R21]
						end
					end
					i2c_mode_pkg::LS_START: begin
						// release data, release clock, pull data low while clock high
						if (l_reg.q == i2c_mode_pkg::Q_DRIVE) begin
							l_next.sda_oe = 1'b0;
						end
						if (l_reg.q == i2c_mode_pkg::Q_HOLD) begin
							l_next.scl_oe = 1'b0;
						end
						if (l_reg.q == i2c_mode_pkg::Q_RISE) begin
							l_next.sda_oe = 1'b1;
						end
						if (l_reg.q == i2c_mode_pkg::Q_SAMPLE) begin
							l_next.scl_oe = 1'b1;
							l_next.st = i2c_mode_pkg::LS_SHIFT;
							l_next.bitcnt = 4'h0;
							l_next.sh = load_byte;
							l_next.recv = load_recv;
							l_next.tg[0] = ~l_reg.tg[0]; // [R7]
						end
					end
					i2c_mode_pkg::LS_SHIFT: begin
						if (l_reg.q == i2c_mode_pkg::Q_DRIVE) begin
							l_next.scl_oe = 1'b1;
							l_next.sda_oe = ~l_reg.recv & ~l_reg.sh[7]; // [R11]
							if (c.loop && l_reg.stage == i2c_mode_pkg::STAGE_DATA
								&& l_reg.bitcnt == 4'h0) begin
								l_next.lp_cnt = i2c_mode_pkg::LOOP_DELAY; // [R14]
								l_next.lp_word = transmit_data;
							end
						end
						if (l_reg.q == i2c_mode_pkg::Q_RISE) begin
							l_next.scl_oe = 1'b0;
						end
						if (l_reg.q == i2c_mode_pkg::Q_SAMPLE) begin
							l_next.sh = {l_reg.sh[6:0], l_reg.recv & sda_now}; // [R18]
							l_next.bitcnt = l_reg.bitcnt + 4'h1;
							if (l_reg.bitcnt + 4'h1 == byte_len) begin
								l_next.st = i2c_mode_pkg::LS_ACK;
							end
						end
					end
					i2c_mode_pkg::LS_ACK: begin
						if (l_reg.q == i2c_mode_pkg::Q_DRIVE) begin
							l_next.scl_oe = 1'b1;
							l_next.sda_oe = l_reg.recv & ~m_nack; // [R2] [R3]
						end
						if (l_reg.q == i2c_mode_pkg::Q_RISE) begin
							l_next.scl_oe = 1'b0;
						end
						if (l_reg.q == i2c_mode_pkg::Q_SAMPLE) begin
							l_next.scl_oe = 1'b1;
							l_next.bitcnt = 4'h0;
							if (l_reg.recv) begin
								l_next.rx_hold = l_reg.sh;
								l_next.tg[3] = ~l_reg.tg[3];
								if (c.noack) begin
									l_next.tg[2] = ~l_reg.tg[2]; // [R3]
								end
							end
							if (l_reg.stage == i2c_mode_pkg::STAGE_SBYTE) begin
								// dummy acknowledge, then repeated start
								l_next.stage = i2c_mode_pkg::STAGE_ADDR_HI; // [R16]
								l_next.st = i2c_mode_pkg::LS_START;
							end else if (l_reg.stage != i2c_mode_pkg::STAGE_DATA) begin
								if (sda_now) begin
									l_next.st = i2c_mode_pkg::LS_STOP;
									l_next.stp_seen = 1'b1;
								end else if (l_reg.stage == i2c_mode_pkg::STAGE_ADDR_HI
									&& c.addr_width) begin
									l_next.stage = i2c_mode_pkg::STAGE_ADDR_LO; // [R12]
									l_next.sh = addr_src[7:0];
									l_next.st = i2c_mode_pkg::LS_SHIFT;
								end else begin
									l_next.stage = i2c_mode_pkg::STAGE_DATA;
									l_next.sh = tx_word;
									l_next.recv = ~c.transmit; // [R11]
									l_next.st = i2c_mode_pkg::LS_SHIFT;
								end
							end else begin
								if (!c.repeat_on) begin
									l_next.cnt = l_reg.cnt - 17'h00001; // [R13] [R23]
								end
								if (c.repeat_on && c.start && !l_reg.stt_seen) begin
									l_next.stt_seen = 1'b1;
									l_next.stage = first_stage; // [R21]
									l_next.st = i2c_mode_pkg::LS_START;
								end else if ((c.stop && (c.repeat_on || m_last))
									|| (!l_reg.recv && sda_now)) begin
									l_next.stp_seen = 1'b1;
									l_next.st = i2c_mode_pkg::LS_STOP; // [R9] [R13]
								end else if (m_last) begin
									l_next.st = i2c_mode_pkg::LS_IDLE; // [R20]
								end else begin
									l_next.sh = tx_word;
									l_next.st = i2c_mode_pkg::LS_SHIFT;
								end
							end
						end
					end
					i2c_mode_pkg::LS_STOP: begin
						// data low, release clock, then release data while clock high
						if (l_reg.q == i2c_mode_pkg::Q_DRIVE) begin
							l_next.scl_oe = 1'b1;
							l_next.sda_oe = 1'b1;
						end
						if (l_reg.q == i2c_mode_pkg::Q_RISE) begin
							l_next.scl_oe = 1'b0;
						end
						if (l_reg.q == i2c_mode_pkg::Q_SAMPLE) begin
							l_next.sda_oe = 1'b0;
							l_next.st = i2c_mode_pkg::LS_IDLE;
							l_next.tg[1] = ~l_reg.tg[1]; // [R9] [R10]
						end
					end
					i2c_mode_pkg::LS_HALT: begin
						l_next.st = i2c_mode_pkg::LS_IDLE;
						l_next.scl_oe = 1'b0;
					end
				endcase
			end
		end else begin
			l_next.q = i2c_mode_pkg::Q_DRIVE;
			if (!c.start || stop_cond) begin
				l_next.st = i2c_mode_pkg::LS_IDLE; // [R8]
				l_next.scl_oe = 1'b0;
				l_next.sda_oe = 1'b0;
			end else if (start_cond) begin
				l_next.st = i2c_mode_pkg::LS_SHIFT;
				l_next.stage = first_stage; // [R17]
				l_next.bitcnt = 4'h0;
				l_next.sda_oe = 1'b0;
				l_next.recv = ~c.free_format | ~c.transmit; // [R11]
				l_next.sh = tx_word;
				l_next.mnack = 1'b0;
			end else begin
				unique case (l_reg.st)
					i2c_mode_pkg::LS_IDLE, i2c_mode_pkg::LS_START, i2c_mode_pkg::LS_STOP: begin
						l_next.st = i2c_mode_pkg::LS_IDLE;
					end
					i2c_mode_pkg::LS_SHIFT: begin
						if (scl_rise) begin
							l_next.sh = {l_reg.sh[6:0], sda_now};
							l_next.bitcnt = l_reg.bitcnt + 4'h1;
						end
						if (scl_fall) begin
							if (l_reg.bitcnt == byte_len) begin
								l_next.st = i2c_mode_pkg::LS_ACK;
								l_next.sda_oe = s_ack; // [R1] [R16]
							end else begin
								l_next.sda_oe = ~l_reg.recv & ~l_reg.sh[7];
							end
						end
					end
					i2c_mode_pkg::LS_ACK: begin
						if (scl_rise && !l_reg.recv && sda_now) begin
							l_next.mnack = 1'b1;
						end
						if (scl_fall) begin
							l_next.sda_oe = 1'b0;
							l_next.bitcnt = 4'h0;
							l_next.mnack = 1'b0;
							if (l_reg.recv && l_reg.stage == i2c_mode_pkg::STAGE_DATA) begin
								l_next.rx_hold = l_reg.sh;
								l_next.tg[3] = ~l_reg.tg[3];
								if (c.noack) begin
									l_next.tg[2] = ~l_reg.tg[2]; // [R3]
								end
							end
							if (l_reg.recv ? ~l_reg.sda_oe : l_reg.mnack) begin
								l_next.st = i2c_mode_pkg::LS_IDLE;
							end else begin
								l_next.st = (halt_now && !c.free_run) ? i2c_mode_pkg::LS_HALT
									: i2c_mode_pkg::LS_SHIFT; // [R6]
								l_next.scl_oe = halt_now & ~c.free_run; // [R6]
								if (l_reg.stage == i2c_mode_pkg::STAGE_ADDR_HI && c.addr_width) begin
									l_next.stage = i2c_mode_pkg::STAGE_ADDR_LO; // [R12]
								end else if (l_reg.stage == i2c_mode_pkg::STAGE_ADDR_HI) begin
									l_next.stage = i2c_mode_pkg::STAGE_DATA;
									l_next.recv = ~l_reg.sh[0];
									l_next.sh = tx_word;
									l_next.sda_oe = l_reg.sh[0] & ~tx_word[7];
								end else if (l_reg.stage == i2c_mode_pkg::STAGE_ADDR_LO) begin
									l_next.stage = i2c_mode_pkg::STAGE_DATA;
									l_next.recv = 1'b1;
								end else if (!l_reg.recv) begin
									l_next.sh = tx_word;
									l_next.sda_oe = ~tx_word[7];
								end
							end
						end
					end
					i2c_mode_pkg::LS_HALT: begin
						if (!halt_now || c.free_run) begin
							l_next.st = i2c_mode_pkg::LS_SHIFT; // [R6]
							l_next.scl_oe = 1'b0;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge link_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			l_reg <= '0;
		end else begin
			l_reg <= l_next;
		end
	end

	// outputs; open-drain pins only ever pull low
	assign mode_rdata = {16'h0000, s_reg.mode}; // [R22]
	assign receive_data = s_reg.rx_data;
	assign receive_strobe = s_reg.rx_pulse;
	assign busy = s_reg.busy_s2;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = l_reg.scl_oe; // [R10]
	assign sda_oe = l_reg.sda_oe;

endmodule : i2c_mode_control

// *** i2c_mode_control_tb.sv ***
// Purpose: self-checking bench of the mode and control block
// Assumes: peer slave model on the wires, pull-ups on both lines
// Notes: expected words queued by the driver, checked by monitors
`timescale 1ns/100ps
module i2c_mode_control_tb;
	logic clock, rst_n, link_clock, mode_write, receive_strobe, busy, debug_halt;
	logic scl_out, scl_oe, sda_out, sda_oe, peer_oe, peer_tgl;
	logic [31:0] mode_wdata, mode_rdata;
	logic [15:0] data_count;
	logic [9:0] target_address, own_address;
	logic [7:0] transmit_data, receive_data, peer_got, reply;
	logic [3:0] peer_ws;
	logic [7:0] exp_rx[$];
	logic [7:0] exp_peer[$];
	int n_mismatch, comparisons;
	wire scl_w = !scl_oe;
	wire #1 sda_w = !(sda_oe || peer_oe); // data lags the clock, a bus hold time

	i2c_mode_control i_i2c_mode_control (.clock(clock), .rst_n(rst_n), .link_clock(link_clock),
		.mode_write(mode_write), .mode_wdata(mode_wdata), .mode_rdata(mode_rdata),
		.data_count(data_count), .target_address(target_address), .own_address(own_address),
		.transmit_data(transmit_data), .receive_data(receive_data),
		.receive_strobe(receive_strobe), .busy(busy), .debug_halt(debug_halt),
		.scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe));
	i2c_peer_model i_i2c_peer_model (.scl(scl_w), .sda(sda_w), .wsize(peer_ws), .reply(reply),
		.sda_oe(peer_oe), .got(peer_got), .got_tgl(peer_tgl));

	// clocks, link clock off phase
	always #2 clock = ~clock;
	initial begin
		link_clock = 1'b0;
		#3.3 link_clock = 1'b1; // one link edge inside reset
		forever #62.5 link_clock = ~link_clock;
	end

	task automatic fail(input string m);
		n_mismatch++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail
	task automatic check_data(input logic [7:0] e, input logic [7:0] g, input string m);
		comparisons++;
		if (g !== e) fail($sformatf("%s got %h want %h", m, g, e));
	endtask : check_data
	task automatic check_mode(input logic [31:0] e);
		comparisons++;
		if (mode_rdata !== e) fail($sformatf("mode got %h want %h", mode_rdata, e));
	endtask : check_mode
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [31:0] v);
		@(negedge clock);
		mode_wdata = v;
		mode_write = 1'b1;
		@(negedge clock);
		mode_write = 1'b0;
	endtask : wr
	// write, then wait for the engine to start and finish
	task automatic run(input logic [31:0] v);
		int i;
		wr(v);
		i = 0;
		while (busy !== 1'b1 && i < 400) begin
			@(negedge clock);
			i++;
		end
		if (i == 400) fail("no bus activity");
		i = 0;
		while (busy !== 1'b0 && i < 30000) begin
			@(negedge clock);
			i++;
		end
		if (i == 30000) fail("transfer hung");
		repeat (40) @(negedge clock);
	endtask : run

	// result monitors
	always @(negedge clock) begin
		if (receive_strobe === 1'b1) begin
			if (exp_rx.size() == 0) fail("unexpected receive word");
			else check_data(exp_rx.pop_front(), receive_data, "rx");
		end
	end
	always @(peer_tgl) begin
		if (rst_n === 1'b1) begin
			if (exp_peer.size() == 0) fail("unexpected bus byte");
			else check_data(exp_peer.pop_front(), peer_got, "bus");
		end
	end

	// watchdog
	initial begin
		#300000;
		fail("watchdog");
		give_verdict();
	end

	// main sequence
	initial begin
		logic [7:0] mask;
		clock = 1'b0;
		rst_n = 1'b0;
		mode_write = 1'b0;
		mode_wdata = 32'h0;
		data_count = 16'h0001;
		target_address = 10'h000;
		own_address = 10'h000;
		transmit_data = 8'h00;
		reply = 8'h00;
		peer_ws = 4'h8;
		debug_halt = 1'b0;
		n_mismatch = 0;
		comparisons = 0;
		void'($urandom(32'h519a));
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		check_mode(32'h0);
		wr(32'hffff_ffdf);
		check_mode(32'h0000_efdf);
		wr(32'h0);
		check_mode(32'h0);
		$display("test reset_reserved done");
		repeat (100) @(negedge clock);
		for (int ws = 0; ws < 8; ws++) begin
			mask = (ws == 0) ? 8'hff : 8'((1 << ws) - 1);
			peer_ws = (ws == 0) ? 4'h8 : 4'(ws);
			target_address = 10'($urandom_range(127, 1));
			transmit_data = 8'($urandom) & mask;
			exp_peer.push_back({target_address[6:0], 1'b0});
			exp_peer.push_back(transmit_data);
			run(32'h2e20 | 32'(ws));
			check_mode(32'h0220 | 32'(ws));
		end
		$display("test master_write done");
		peer_ws = 4'h8;
		reply = 8'($urandom);
		data_count = 16'h0002;
		exp_peer.push_back({target_address[6:0], 1'b1});
		exp_peer.push_back(8'h00);
		exp_peer.push_back(8'h01);
		exp_rx.push_back(reply);
		exp_rx.push_back(reply);
		run(32'h2c20);
		check_mode(32'h0020);
		$display("test master_read done");
		// noack asked in the starting write, well before any data bit rises
		reply = 8'($urandom);
		exp_peer.push_back({target_address[6:0], 1'b1});
		exp_peer.push_back(8'h01);
		exp_rx.push_back(reply);
		exp_rx.push_back(8'hff);
		run(32'hac20);
		check_mode(32'h0020);
		$display("test noack_request done");
		own_address = 10'($urandom_range(127, 1));
		transmit_data = 8'($urandom);
		data_count = 16'h0001;
		exp_peer.push_back({own_address[6:0], 1'b0});
		exp_peer.push_back(transmit_data);
		exp_rx.push_back(transmit_data);
		run(32'h2e60);
		check_mode(32'h0260);
		$display("test loopback done");
		run(32'h0c20);
		check_mode(32'h0020);
		$display("test stop_only done");
		wr(32'h2ea0);
		repeat (300) @(negedge clock);
		check_mode(32'h2ea0);
		wr(32'h0);
		$display("test reserved_combo done");
		repeat (10) @(negedge clock);
		if (exp_rx.size() + exp_peer.size() != 0) fail("results missing");
		give_verdict();
	end
endmodule : i2c_mode_control_tb

// *** i2c_mode_pkg.sv ***
// Purpose: constants and types for the two-wire bus mode and control block
// Assumes: mode register lives in the system clock domain, bus engine on link_clock
// Notes: field layout of the mode register is the mode_control_type struct
// Overview of operation
// [R1] slave receiver acknowledges unless noack requested
// [R2] master receiver acknowledges until counter hits zero
// [R3] noack request sends one noack, then self-clears
// [R4] software sets noack before last bit rises
// [R5] master halt freezes with clock held low; code can freeze between bits at Q_DRIVE with the clock still released
// [R6] slave halt waits for byte end; free ignores
// [R7] master start request makes START, then self-clears
// [R8] slave monitors bus only while start set
// [R9] stop request makes STOP at count zero
// [R10] master select; cleared when master STOP generated
// [R11] transmit select picks transmitter or receiver
// [R12] address width picks 7 or 10 bits
// [R13] repeat mode ignores count until stop
// [R14] loopback returns words after eight module cycles; code counts eight link_clock cycles
// [R15] module enable low holds block disabled, released
// [R16] start byte mode sends 01h, dummy ack, restart
// [R17] free format skips addressing entirely; code still sends the address after a start byte and its restart
// [R18] word size zero means eight, right aligned
// [R19] software matches word size, right-aligns transmit
// [R20] non-repeat start/stop combinations define bus activity
// [R21] repeat start/stop combinations; both reserved, idle
// [R22] reserved mode bits read zero, ignore writes
// [R23] zero count loads 65536, decrements per word
package i2c_mode_pkg;

	localparam int MODE_WIDTH = 16;
	localparam int RESERVED_POS = 12;
	localparam logic [15:0] MODE_WRITE_MASK = ~(16'h0001 << RESERVED_POS);
	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [7:0] START_BYTE = 8'h01;
	localparam logic [16:0] COUNT_ZERO_LOAD = 17'h10000;
	localparam logic [16:0] COUNT_LAST = 17'h00001;
	localparam logic [4:0] TEN_BIT_HEADER = 5'h1e;
	localparam logic [3:0] LOOP_DELAY = 4'h8;
	localparam logic [3:0] FULL_WORD = 4'h8;
	localparam logic [1:0] Q_DRIVE = 2'h0;
	localparam logic [1:0] Q_HOLD = 2'h1;
	localparam logic [1:0] Q_RISE = 2'h2;
	localparam logic [1:0] Q_SAMPLE = 2'h3;
	localparam logic [1:0] STAGE_SBYTE = 2'h0;
	localparam logic [1:0] STAGE_ADDR_HI = 2'h1;
	localparam logic [1:0] STAGE_ADDR_LO = 2'h2;
	localparam logic [1:0] STAGE_DATA = 2'h3;

	// mode register layout, bit 15 down to bit 0
	typedef struct packed {
		logic noack;
		logic free_run;
		logic start;
		logic reserved_12;
		logic stop;
		logic master;
		logic transmit;
		logic addr_width;
		logic repeat_on;
		logic loop;
		logic enable;
		logic sbyte;
		logic free_format;
		logic [2:0] word_size;
	} mode_control_type;

	typedef enum logic [2:0] {
		LS_IDLE = 3'b000,
		LS_START = 3'b001,
		LS_SHIFT = 3'b011,
		LS_ACK = 3'b010,
		LS_STOP = 3'b110,
		LS_HALT = 3'b100
	} link_state_type;

endpackage : i2c_mode_pkg

// *** i2c_peer_model.sv ***
// Purpose: behavioural slave on the far side of the two-wire bus
// Assumes: pulled-up lines, released sda reads high
// Notes: acks every byte it receives; reports bytes and master acks
`timescale 1ns/100ps
module i2c_peer_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic [3:0] wsize,
	input wire logic [7:0] reply,
	output logic sda_oe,
	output logic [7:0] got,
	output logic got_tgl
);
	logic rd;
	initial begin
		sda_oe = 1'b0;
		got = 8'h00;
		got_tgl = 1'b0;
	end
	// shift n bits msb first, right aligned; reported at the next scl fall,
	// so the clock rise of a STOP never completes a word
	task automatic take(input logic [3:0] n);
		logic [7:0] b;
		b = 8'h00;
		repeat (n) begin
			@(posedge scl);
			b = {b[6:0], sda};
		end
		@(negedge scl);
		got = b;
		got_tgl = ~got_tgl;
	endtask : take
	// one frame from start to stop
	always begin
		@(negedge sda iff scl === 1'b1);
		fork
			begin
				take(4'h8);
				rd = got[0];
				sda_oe = 1'b1;
				@(negedge scl);
				forever if (rd) begin
					for (int i = 7; i >= 0; i--) begin
						sda_oe = ~reply[i];
						@(negedge scl);
					end
					sda_oe = 1'b0;
					@(posedge scl);
					got = {7'h00, sda};
					got_tgl = ~got_tgl;
					if (sda) wait (1'b0);
					@(negedge scl);
				end else begin
					sda_oe = 1'b0;
					take(wsize);
					sda_oe = 1'b1;
					@(negedge scl);
				end
			end
			@(posedge sda iff scl === 1'b1);
		join_any
		disable fork;
		sda_oe = 1'b0;
	end
endmodule : i2c_peer_model
